// ### verilog/rrr_regs.svh
// Register offsets, field positions, reset values and codes for the relative/resolution block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef RRR_REGS_SVH
`define RRR_REGS_SVH

`define RRR_OFF_CMD        8'h00
`define RRR_OFF_REF_VALUE  8'h04
`define RRR_OFF_REL_EN     8'h08
`define RRR_OFF_STATUS     8'h0C
`define RRR_OFF_IRQ_STAT   8'h10
`define RRR_OFF_IRQ_MASK   8'h14
`define RRR_OFF_REF_QUERY  8'h18
`define RRR_OFF_RES_QUERY  8'h1C
`define RRR_OFF_READING    8'h20

`define RRR_CMD_OP_LSB     0
`define RRR_CMD_FUNC_LSB   4
`define RRR_CMD_PARAM_LSB  8

`define RRR_ST_ERR_BIT     0
`define RRR_ST_CAPSRC_BIT  1
`define RRR_ST_READY_BIT   2

`define RRR_IRQ_DONE_BIT   0
`define RRR_IRQ_ERR_BIT    1
`define RRR_IRQ_READ_BIT   2

`define RRR_REL_EN_RESET   9'h000
`define RRR_RES_RESET      3'h5
`define RRR_RES_MIN        3'h4
`define RRR_RES_MAX        3'h7
`define RRR_NUM_FUNCS      9

`endif

// ### verilog/rrr_pkg.sv
// Types shared by the relative/resolution block.
// Assumes rrr_regs.svh supplies the numeric constants.
package rrr_pkg;

  typedef enum logic [2:0] {
    RRR_OP_NOP     = 3'b000,
    RRR_OP_REL_SET = 3'b001,
    RRR_OP_REF_SET = 3'b010,
    RRR_OP_CAPTURE = 3'b011,
    RRR_OP_RES_SET = 3'b100
  } rrr_op_e;

  typedef enum logic [3:0] {
    RRR_FN_ACI  = 4'b0000,
    RRR_FN_DCI  = 4'b0001,
    RRR_FN_ACV  = 4'b0010,
    RRR_FN_DCV  = 4'b0011,
    RRR_FN_RES2 = 4'b0100,
    RRR_FN_RES4 = 4'b0101,
    RRR_FN_FRQ  = 4'b0110,
    RRR_FN_PRD  = 4'b0111,
    RRR_FN_TMP  = 4'b1000
  } rrr_func_e;

  typedef enum logic [1:0] {
    RRR_ST_IDLE = 2'b00,
    RRR_ST_EXEC = 2'b01,
    RRR_ST_DONE = 2'b10
  } rrr_state_e;

endpackage

// ### verilog/rrr_round.sv
// Rounds a fixed-point resolution parameter to the nearest integer code.
// Assumes an unsigned value with FRAC fraction bits; halves round up.
`timescale 1ns/1ps

module rrr_round #(
  parameter int IN_W = 8,
  parameter int FRAC = 4
) (
  // Fixed-point input
  input  wire logic [IN_W-1:0]      value_i,
  // Rounded integer code, saturated to 3 bits
  output logic      [2:0]           code_o
);

  logic [IN_W:0] sum;
  logic [IN_W:0] whole;

  // Add one half then drop the fraction; wide sum avoids a carry loss
  always_comb begin
    sum   = {1'b0, value_i} + (IN_W+1)'(1 << (FRAC-1));
    whole = sum >> FRAC;
    if (whole > (IN_W+1)'(7)) begin
      code_o = 3'h7;
    end else begin
      code_o = whole[2:0];
    end
  end

endmodule

// ### verilog/rrr_sub.sv
// Signed subtraction of the reference from the measured value.
// Assumes two's complement operands of equal width.
`timescale 1ns/1ps

module rrr_sub #(
  parameter int W = 24
) (
  // Operands
  input  wire logic signed [W-1:0] meas_i,
  input  wire logic signed [W-1:0] ref_i,
  input  wire logic                en_i,
  // Result
  output logic signed      [W-1:0] out_o
);

  // Bypass when relative is off so the raw reading passes through
  always_comb begin
    if (en_i) begin
      out_o = meas_i - ref_i;
    end else begin
      out_o = meas_i;
    end
  end

endmodule

// ### verilog/rrr_top.sv
// Relative reference and display resolution control, reached over classic Wishbone.
// Assumes the measurement chain presents its latest reading, flags and function synchronously.
`timescale 1ns/1ps
`include "rrr_regs.svh"

module rrr_top #(
  parameter int DW   = 24,
  parameter int NF   = `RRR_NUM_FUNCS,
  parameter int FRAC = 4
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Measurement chain
  input  wire logic [DW-1:0] meas_value_i,
  input  wire logic          meas_valid_i,
  input  wire logic          overflow_indication_i,
  input  wire logic [3:0]    cur_func_i,
  // Processed reading
  output logic [DW-1:0]      reading_o,
  output logic               reading_valid_o,
  // Interrupt
  output logic               irq_o
);

  rrr_pkg::rrr_state_e state_reg;
  logic [NF-1:0]       relative_mode_reg;
  logic [NF-1:0]       capsrc_reg;
  logic [DW-1:0]       ref_prog_reg [NF];
  logic [DW-1:0]       ref_cap_reg  [NF];
  logic [2:0]          res_reg      [NF];
  logic [DW-1:0]       ref_value_reg;
  logic [31:0]         cmd_reg;
  logic                err_reg;
  logic                have_reading_reg;
  logic                last_overflow_indication_reg;
  logic [DW-1:0]       last_meas_reg;
  logic [2:0]          irq_stat_reg;
  logic [2:0]          irq_mask_reg;
  logic                ev_done;
  logic                ev_err;
  logic                cmd_go;
  logic                stat_rd;
  logic [3:0]          cmd_fn;
  logic [2:0]          cmd_op;
  logic [2:0]          res_code;
  logic                cap_bad;
  logic [DW-1:0]       sel_ref;
  logic                sel_en;
  logic [DW-1:0]       sub_out;
  logic [3:0]          q_fn;
  logic                wr_acc;
  logic                rd_acc;

  // Index guard shared by command and query paths
  function automatic logic fn_ok(input logic [3:0] f);
    fn_ok = (f < 4'(NF));
  endfunction

  function automatic logic [DW-1:0] ref_of(input logic [3:0] f, input logic src,
                                           input logic [DW-1:0] p, input logic [DW-1:0] c);
    ref_of = src ? c : p;
  endfunction

  assign wr_acc  = cyc_i && stb_i && !ack_o && we_i;
  assign rd_acc  = cyc_i && stb_i && !ack_o && !we_i;
  assign cmd_go  = wr_acc && (adr_i == `RRR_OFF_CMD) && sel_i[0];
  assign stat_rd = rd_acc && (adr_i == `RRR_OFF_IRQ_STAT);
  assign cmd_op  = cmd_reg[`RRR_CMD_OP_LSB +: 3];
  assign cmd_fn  = cmd_reg[`RRR_CMD_FUNC_LSB +: 4];
  assign q_fn    = cmd_fn;

  // Capture is refused for wrong function, overflow, or no reading yet
  assign cap_bad = !fn_ok(cmd_fn) || (cmd_fn != cur_func_i)
                   || last_overflow_indication_reg || !have_reading_reg;

  // Rounding of the resolution parameter
  rrr_round #(
    .IN_W (8),
    .FRAC (FRAC)
  ) u_round (
    .value_i (cmd_reg[`RRR_CMD_PARAM_LSB +: 8]),
    .code_o  (res_code)
  );

  // Reference and enable for the function being measured
  always_comb begin
    sel_ref = '0;
    sel_en  = 1'b0;
    if (fn_ok(cur_func_i)) begin
      sel_ref = ref_of(cur_func_i, capsrc_reg[cur_func_i],
                       ref_prog_reg[cur_func_i], ref_cap_reg[cur_func_i]);
      sel_en  = relative_mode_reg[cur_func_i];
    end
  end

  rrr_sub #(
    .W (DW)
  ) u_sub (
    .meas_i (meas_value_i),
    .ref_i  (sel_ref),
    .en_i   (sel_en),
    .out_o  (sub_out)
  );

  // Wishbone acknowledge: one cycle after the strobe, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Command and reference value registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg       <= 32'h0000_0000;
      ref_value_reg <= '0;
    end else if (wr_acc) begin
      if (adr_i == `RRR_OFF_CMD) begin
        cmd_reg <= dat_i;
      end
      if (adr_i == `RRR_OFF_REF_VALUE) begin
        ref_value_reg <= dat_i[DW-1:0];
      end
    end
  end

  // Command sequencer: a write to the command register starts one execution
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= rrr_pkg::RRR_ST_IDLE;
    end else begin
      case (state_reg)
        rrr_pkg::RRR_ST_IDLE: begin
          if (cmd_go) begin
            state_reg <= rrr_pkg::RRR_ST_EXEC;
          end
        end
        rrr_pkg::RRR_ST_EXEC: begin
          state_reg <= rrr_pkg::RRR_ST_DONE;
        end
        rrr_pkg::RRR_ST_DONE: begin
          state_reg <= rrr_pkg::RRR_ST_IDLE;
        end
        default: begin
          state_reg <= rrr_pkg::RRR_ST_IDLE;
        end
      endcase
    end
  end

  // Per-function state, one slice per function
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_fn
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          relative_mode_reg[g] <= 1'b0;
          capsrc_reg[g]        <= 1'b0;
          ref_prog_reg[g]      <= '0;
          ref_cap_reg[g]       <= '0;
          res_reg[g]           <= `RRR_RES_RESET;
        end else if (state_reg == rrr_pkg::RRR_ST_EXEC && cmd_fn == 4'(g)) begin
          case (cmd_op)
            rrr_pkg::RRR_OP_REL_SET: begin
              relative_mode_reg[g] <= cmd_reg[`RRR_CMD_PARAM_LSB];
            end
            rrr_pkg::RRR_OP_REF_SET: begin
              ref_prog_reg[g] <= ref_value_reg;
              capsrc_reg[g]   <= 1'b0;
            end
            rrr_pkg::RRR_OP_CAPTURE: begin
              // A refused capture touches nothing
              if (!cap_bad) begin
                ref_cap_reg[g] <= last_meas_reg;
                capsrc_reg[g]  <= 1'b1;
              end
            end
            rrr_pkg::RRR_OP_RES_SET: begin
              // Out-of-range codes are ignored so a bad value cannot stick
              if (res_code >= `RRR_RES_MIN && res_code <= `RRR_RES_MAX) begin
                res_reg[g] <= res_code;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  endgenerate

  // Latest reading tracking for capture checks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      have_reading_reg <= 1'b0;
      last_overflow_indication_reg    <= 1'b0;
      last_meas_reg    <= '0;
    end else if (meas_valid_i) begin
      have_reading_reg <= 1'b1;
      last_overflow_indication_reg    <= overflow_indication_i;
      last_meas_reg    <= meas_value_i;
    end
  end

  // Command error flag, refreshed at each executed command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_reg <= 1'b0;
    end else if (state_reg == rrr_pkg::RRR_ST_EXEC) begin
      err_reg <= (cmd_op == rrr_pkg::RRR_OP_CAPTURE) ? cap_bad : !fn_ok(cmd_fn);
    end
  end

  assign ev_done = (state_reg == rrr_pkg::RRR_ST_DONE);
  assign ev_err  = ev_done && err_reg;

  // Sticky events; a new event wins over the read that clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (stat_rd ? 3'h0 : irq_stat_reg)
                      | {meas_valid_i, ev_err, ev_done};
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_acc && adr_i == `RRR_OFF_IRQ_MASK) begin
      irq_mask_reg <= dat_i[2:0];
    end
  end

  // Registered level interrupt from the next status (read clear and new events applied) and the current mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((stat_rd ? 3'h0 : irq_stat_reg) & irq_mask_reg)
               | |({meas_valid_i, ev_err, ev_done} & irq_mask_reg);
    end
  end

  // Processed reading output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reading_o       <= '0;
      reading_valid_o <= 1'b0;
    end else begin
      reading_valid_o <= meas_valid_i;
      if (meas_valid_i) begin
        reading_o <= sub_out;
      end
    end
  end

  // Read data; unmapped addresses return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_acc) begin
      dat_o <= 32'h0000_0000;
      case (adr_i)
        `RRR_OFF_CMD:       dat_o <= cmd_reg;
        `RRR_OFF_REF_VALUE: dat_o <= 32'(ref_value_reg);
        `RRR_OFF_REL_EN:    dat_o <= 32'(relative_mode_reg);
        `RRR_OFF_STATUS: begin
          dat_o[`RRR_ST_ERR_BIT]   <= err_reg;
          dat_o[`RRR_ST_CAPSRC_BIT] <= fn_ok(q_fn) ? capsrc_reg[q_fn] : 1'b0;
          dat_o[`RRR_ST_READY_BIT] <= have_reading_reg;
        end
        `RRR_OFF_IRQ_STAT:  dat_o <= {29'h0, irq_stat_reg};
        `RRR_OFF_IRQ_MASK:  dat_o <= {29'h0, irq_mask_reg};
        `RRR_OFF_REF_QUERY: begin
          if (fn_ok(q_fn)) begin
            dat_o <= 32'(ref_of(q_fn, capsrc_reg[q_fn],
                                ref_prog_reg[q_fn], ref_cap_reg[q_fn]));
          end
        end
        `RRR_OFF_RES_QUERY: begin
          if (fn_ok(q_fn)) begin
            dat_o <= {29'h0, res_reg[q_fn]};
          end
        end
        `RRR_OFF_READING:   dat_o <= 32'(reading_o);
        default: begin
        end
      endcase
    end
  end

endmodule

// ### verification/rrr_top_sva.sv
// Port-level checks for the relative/resolution block.
// Assumes it is bound to rrr_top and sees its ports only.
`timescale 1ns/1ps

module rrr_chk #(
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          rst_i,
  // Bus
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic          we_i,
  input wire logic [31:0]   dat_o,
  input wire logic          ack_o,
  // Readings
  input wire logic          meas_valid_i,
  input wire logic [DW-1:0] reading_o,
  input wire logic          reading_valid_o,
  input wire logic          irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus handshake: one-cycle answer, one-cycle pulse
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  ack_spur_a: assert property (!(cyc_i && stb_i && !ack_o) |=> !ack_o)
    else $error("ack without request");
  rdata_hold_a: assert property (!(cyc_i && stb_i && !ack_o && !we_i) |=> $stable(dat_o))
    else $error("read data moved without a read");
  // Processed reading follows each new reading by one cycle
  rv_next_a: assert property (meas_valid_i |=> reading_valid_o)
    else $error("processed reading missing");
  rv_only_a: assert property (!meas_valid_i |=> !reading_valid_o)
    else $error("processed reading without input");
  rdg_hold_a: assert property (!meas_valid_i |=> $stable(reading_o))
    else $error("reading changed without input");
  // Reset values are checked during reset itself, so no disable here
  rst_vals_a: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !irq_o && !reading_valid_o && reading_o == '0)
    else $error("outputs not cleared by reset");
endmodule

// ### verification/rrr_meas_model.sv
// Behavioural model of the measurement chain feeding the block.
// Assumes the bench raises fire_i for one cycle per reading.
`timescale 1ns/1ps

module rrr_meas_model (
  // Clock and bench request
  input  wire logic        clk_i,
  input  wire logic        fire_i,
  input  wire logic [23:0] val_i,
  input  wire logic        ovf_i,
  // Toward the block
  output logic      [23:0] meas_value_o,
  output logic             meas_valid_o,
  output logic             ovf_o
);
  initial begin
    meas_value_o = 24'h00_0000;
    meas_valid_o = 1'b0;
    ovf_o        = 1'b0;
  end

  // Outside a reading value and flag toggle, so a stale value is never trusted
  always @(posedge clk_i) begin
    meas_valid_o <= fire_i;
    meas_value_o <= fire_i ? val_i : ~meas_value_o;
    ovf_o        <= fire_i ? ovf_i : ~ovf_o;
  end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the relative/resolution block.
// Assumes the checker and the measurement model are compiled first.
`timescale 1ns/1ps
`include "rrr_regs.svh"

module testbench;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, fire, ovf;
  logic        meas_valid_i, overflow_indication_i, reading_valid_o, irq_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, cur_func_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [23:0] meas_value_i, reading_o, mval;
  int          n_fail, tests_run, cyc_cnt;

  rrr_top #(.DW(24), .NF(9), .FRAC(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .meas_value_i(meas_value_i), .meas_valid_i(meas_valid_i),
    .overflow_indication_i(overflow_indication_i), .cur_func_i(cur_func_i),
    .reading_o(reading_o), .reading_valid_o(reading_valid_o), .irq_o(irq_o));
  rrr_meas_model model_u (.clk_i(clk_i), .fire_i(fire), .val_i(mval), .ovf_i(ovf),
    .meas_value_o(meas_value_i), .meas_valid_o(meas_valid_i), .ovf_o(overflow_indication_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Three idle cycles keep the next command clear of the one executing
  task automatic cmd(input logic [2:0] op, input logic [3:0] fn, input logic [7:0] p);
    wb(1'b1, `RRR_OFF_CMD, {16'h0000, p, fn, 1'b0, op});
    repeat (3) @(posedge clk_i);
  endtask

  task automatic meas(input logic [23:0] v, input logic o);
    fire <= 1'b1;
    mval <= v;
    ovf  <= o;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_reset();
    chk({8'h00, reading_o}, 32'h0000_0000);
    rdchk(`RRR_OFF_REL_EN, 32'h0000_0000);
    cmd(3'h0, 4'h6, 8'h00);
    rdchk(`RRR_OFF_RES_QUERY, 32'h0000_0005);
    rdchk(8'h3C, 32'h0000_0000);
    // A function code past the last one is an error and leaves every enable alone
    cmd(3'h1, 4'h9, 8'h01);
    rdchk(`RRR_OFF_STATUS, 32'h0000_0001);
    rdchk(`RRR_OFF_REL_EN, 32'h0000_0000);
  endtask

  task automatic t_rel();
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int f = 0; f < 9; f += 2) begin
      cmd(3'h1, f[3:0], 8'h01);
      m[f] = 1'b1;
    end
    rdchk(`RRR_OFF_REL_EN, m);
    cmd(3'h1, 4'h4, 8'h00);
    rdchk(`RRR_OFF_REL_EN, 32'h0000_0145);
  endtask

  task automatic t_cap();
    cur_func_i <= 4'h3;
    cmd(3'h3, 4'h3, 8'h00);
    rdchk(`RRR_OFF_STATUS, 32'h0000_0001);
    meas(24'h00_0100, 1'b1);
    cmd(3'h3, 4'h3, 8'h00);
    rdchk(`RRR_OFF_STATUS, 32'h0000_0005);
    meas(24'h00_0100, 1'b0);
    cmd(3'h3, 4'h2, 8'h00);
    rdchk(`RRR_OFF_STATUS, 32'h0000_0005);
    rdchk(`RRR_OFF_REF_QUERY, 32'h0000_0000);
    rdchk(`RRR_OFF_REL_EN, 32'h0000_0145);
    cmd(3'h3, 4'h3, 8'h00);
    rdchk(`RRR_OFF_STATUS, 32'h0000_0006);
    rdchk(`RRR_OFF_REF_QUERY, 32'h0000_0100);
  endtask

  task automatic t_sub();
    cmd(3'h1, 4'h3, 8'h01);
    meas(24'h00_0040, 1'b0);
    chk({8'h00, reading_o}, 32'h00FF_FF40);
    rdchk(`RRR_OFF_READING, 32'h00FF_FF40);
    cur_func_i <= 4'h4;
    meas(24'h00_0040, 1'b0);
    chk({8'h00, reading_o}, 32'h0000_0040);
  endtask

  task automatic t_refset();
    wb(1'b1, `RRR_OFF_REF_VALUE, 32'h00FF_FFF0);
    cmd(3'h2, 4'h3, 8'h00);
    rdchk(`RRR_OFF_REF_QUERY, 32'h00FF_FFF0);
    rdchk(`RRR_OFF_STATUS, 32'h0000_0004);
    cur_func_i <= 4'h3;
    meas(24'h00_0010, 1'b0);
    chk({8'h00, reading_o}, 32'h0000_0020);
  endtask

  // Halves round up; a code outside 4..7 leaves the setting alone
  task automatic t_res();
    logic [7:0] p [5] = '{8'h38, 8'h48, 8'h46, 8'h6C, 8'h28};
    logic [2:0] c [5] = '{3'h4, 3'h5, 3'h4, 3'h7, 3'h7};
    for (int i = 0; i < 5; i++) begin
      cmd(3'h4, 4'h1, p[i]);
      rdchk(`RRR_OFF_RES_QUERY, {29'h0, c[i]});
    end
    cmd(3'h0, 4'h6, 8'h00);
    rdchk(`RRR_OFF_RES_QUERY, 32'h0000_0005);
  endtask

  task automatic t_irq();
    wb(1'b1, `RRR_OFF_IRQ_MASK, 32'h0000_0002);
    wb(1'b0, `RRR_OFF_IRQ_STAT, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    cmd(3'h3, 4'h5, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wb(1'b0, `RRR_OFF_IRQ_STAT, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    wb(1'b1, `RRR_OFF_IRQ_MASK, 32'h0000_0004);
    rdchk(`RRR_OFF_IRQ_MASK, 32'h0000_0004);
    meas(24'h00_0001, 1'b0);
    chk({31'h0, irq_o}, 32'h0000_0001);
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    cyc_cnt = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0000_0000;
    fire = 1'b0;
    mval = 24'h00_0000;
    ovf = 1'b0;
    cur_func_i = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_rel();
    t_cap();
    t_sub();
    t_refset();
    t_res();
    t_irq();
    summarize();
  end
endmodule

bind rrr_top rrr_chk #(.DW(DW)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .meas_valid_i(meas_valid_i),
  .reading_o(reading_o), .reading_valid_o(reading_valid_o), .irq_o(irq_o));
